// ===== rtl/dac_cmd_pkg.sv
// shared constants, command codes and carrier types of the dac command decoder
package dac_cmd_pkg;

   localparam int NUM_CH     = 8;
   localparam int CODE_W     = 16;
   localparam int FRAME_BITS = 32;
   localparam int SET_W      = 12;
   localparam int MUX_SEL_W  = 10;
   localparam int FAULT_W    = 3;

   // 1: 16-bit variant, 0: 12-bit variant
   localparam bit WIDE_CODE = 1'b1;

   // link framing
   localparam logic [5:0] LAST_BIT   = 6'h1f;
   localparam logic [5:0] FRAME_DONE = 6'h20;

   // write commands
   localparam logic [7:0] CMD_TOG_EN       = 8'h74;
   localparam logic [7:0] CMD_MUX          = 8'h75;
   localparam logic [7:0] CMD_FAULT        = 8'h76;
   localparam logic [7:0] CMD_CODE_ALL     = 8'h78;
   localparam logic [7:0] CMD_CODE_UPD_ALL = 8'h79;
   localparam logic [7:0] CMD_SET_ALL      = 8'h7a;
   localparam logic [7:0] CMD_SET_UPD_ALL  = 8'h7b;
   localparam logic [7:0] CMD_UPD_ALL      = 8'h7c;

   // global read commands and the no-operation code
   localparam logic [7:0] CMD_RD_CFG     = 8'hf0;
   localparam logic [7:0] CMD_RD_PWRDN   = 8'hf1;
   localparam logic [7:0] CMD_RD_ABSEL   = 8'hf2;
   localparam logic [7:0] CMD_RD_SWTOG   = 8'hf3;
   localparam logic [7:0] CMD_RD_TOG_EN  = 8'hf4;
   localparam logic [7:0] CMD_RD_MUX     = 8'hf5;
   localparam logic [7:0] CMD_RD_FAULT   = 8'hf6;
   localparam logic [7:0] CMD_RD_THERMAL = 8'hf7;
   localparam logic [7:0] CMD_NOP        = 8'hff;

   // per-channel read command nibbles
   localparam logic [3:0] NIB_RD_CODE = 4'h8;
   localparam logic [3:0] NIB_RD_SET  = 4'h9;
   localparam logic [3:0] NIB_RD_OFS  = 4'ha;
   localparam logic [3:0] NIB_RD_GAIN = 4'hb;

   // field positions inside the 24-bit data field
   localparam int CODE16_LSB  = 8;
   localparam int CODE12_LSB  = 12;
   localparam int SET_LSB     = 8;
   localparam int TOG_LSB     = 8;
   localparam int MUX_ON_BIT  = 18;
   localparam int MUX_SEL_LSB = 8;
   localparam int FAULT_LSB   = 8;
   localparam int THERM_LSB   = 8;

   // reset values
   localparam logic [CODE_W-1:0]    RST_CODE    = 16'h0000;
   localparam logic [MUX_SEL_W-1:0] RST_MUX_SEL = 10'h000;
   localparam logic [NUM_CH-1:0]    RST_TOG_EN  = 8'h00;

   typedef struct packed {
      logic [7:0]  cmd;
      logic [23:0] data;
   } frame_t;

   typedef struct packed {
      logic       spare;
      logic [1:0] ditherPhase;
      logic [2:0] ditherPeriod;
      logic [1:0] toggleSourceSelect;
      logic [3:0] spanSetting;
   } chan_set_t;

   typedef struct packed {
      logic thermalShutdownFault;
      logic clockIntegrityFault;
      logic commandIntegrityFault;
   } fault_t;

   localparam chan_set_t RST_SET   = 12'h000;
   localparam fault_t    RST_FAULT = 3'h0;

   function automatic logic [CODE_W-1:0] pickCode(input logic [23:0] d);
      pickCode = WIDE_CODE ? d[CODE16_LSB +: CODE_W]
                           : {4'h0, d[CODE12_LSB +: 12]};
   endfunction

endpackage

// ===== rtl/dac_serial_command_decoder.sv
// serial command decoder: link shifter, frame crossing, command execution
`timescale 1ns/1ns
module dac_serial_command_decoder (
   input  wire logic                                  clk_sys,
   input  wire logic                                  reset,
   input  wire logic                                  sclkLink,
   input  wire logic                                  csN,
   input  wire logic                                  sdi,
   output logic                                       sdo,
   input  wire logic [dac_cmd_pkg::FAULT_W-1:0]       faultSetIn,
   input  wire logic [dac_cmd_pkg::NUM_CH-1:0]        thermalStatusIn,
   output logic [dac_cmd_pkg::NUM_CH-1:0]
                    [dac_cmd_pkg::CODE_W-1:0]         dacCodeWord,
   output dac_cmd_pkg::chan_set_t [dac_cmd_pkg::NUM_CH-1:0] chanSetting,
   output logic [dac_cmd_pkg::NUM_CH-1:0]             toggleDitherEnableBits,
   output logic                                       monitorMuxOn,
   output logic [dac_cmd_pkg::MUX_SEL_W-1:0]          monitorSelectCode,
   output dac_cmd_pkg::fault_t                        faultFlags
);

   localparam int NCH = dac_cmd_pkg::NUM_CH;
   localparam int CW  = dac_cmd_pkg::CODE_W;

   default clocking cbSys @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // link domain
   logic                   linkClear;
   logic [5:0]             bitCnt_ff;
   logic [31:0]            shiftIn_ff;
   dac_cmd_pkg::frame_t    frameHold_ff;
   logic                   frameTog_ff;

   // system domain
   logic                   togMeta_ff;
   logic                   togSync_ff;
   logic                   togSeen_ff;
   logic                   newFrame;
   logic [7:0]             cmd;
   logic [23:0]            data;
   logic [3:0]             chanAddr;
   logic                   chanValid;
   logic [CW-1:0]          newCode;
   logic [NCH-1:0][CW-1:0] inReg_ff;
   logic [31:0]            readHold_ff;
   logic [31:0]            nxt_readHold;
   logic                   readHit;
   logic [dac_cmd_pkg::FAULT_W-1:0] faultMeta_ff;
   logic [dac_cmd_pkg::FAULT_W-1:0] faultSync_ff;
   logic [NCH-1:0]         thermMeta_ff;
   logic [NCH-1:0]         thermSync_ff;

   // write strobes
   logic wrTogEn;
   logic wrMux;
   logic wrFault;
   logic wrCodeAll;
   logic wrCodeUpd;
   logic wrSetAll;
   logic wrSetUpd;
   logic wrUpdAll;
   logic loadAllCode;
   logic copyAll;

   // frame ends with the chip select; no sclk edge is assumed outside it
   assign linkClear = reset | csN;

   always_ff @(posedge sclkLink or posedge linkClear) begin
      if (linkClear) begin
         bitCnt_ff  <= 6'h00;
         shiftIn_ff <= 32'h0000_0000;
      end else if (bitCnt_ff != dac_cmd_pkg::FRAME_DONE) begin
         shiftIn_ff <= {shiftIn_ff[30:0], sdi};
         bitCnt_ff  <= bitCnt_ff + 6'h01;
      end
   end

   // only the first 32 bits of a frame count; short frames are dropped
   always_ff @(posedge sclkLink or posedge reset) begin
      if (reset) begin
         frameHold_ff <= '0;
         frameTog_ff  <= 1'b0;
      end else if (!csN && bitCnt_ff == dac_cmd_pkg::LAST_BIT) begin
         frameHold_ff <= {shiftIn_ff[30:0], sdi};
         frameTog_ff  <= ~frameTog_ff;
      end
   end

   // readback leaves msb first, changing on rising sclk
   always_ff @(posedge sclkLink or posedge linkClear) begin
      if (linkClear) begin
         sdo <= 1'b0;
      end else if (bitCnt_ff != dac_cmd_pkg::FRAME_DONE) begin
         sdo <= readHold_ff[5'(dac_cmd_pkg::LAST_BIT - bitCnt_ff)];
      end
   end

   // frame toggle crossing; the held word is stable long before it is used
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         togMeta_ff <= 1'b0;
         togSync_ff <= 1'b0;
         togSeen_ff <= 1'b0;
      end else begin
         togMeta_ff <= frameTog_ff;
         togSync_ff <= togMeta_ff;
         togSeen_ff <= togSync_ff;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         faultMeta_ff <= '0;
         faultSync_ff <= '0;
         thermMeta_ff <= '0;
         thermSync_ff <= '0;
      end else begin
         faultMeta_ff <= faultSetIn;
         faultSync_ff <= faultMeta_ff;
         thermMeta_ff <= thermalStatusIn;
         thermSync_ff <= thermMeta_ff;
      end
   end

   assign newFrame  = togSync_ff ^ togSeen_ff;
   assign cmd       = frameHold_ff.cmd;
   assign data      = frameHold_ff.data;
   assign chanAddr  = cmd[3:0];
   assign chanValid = (chanAddr < 4'(NCH));
   assign newCode   = dac_cmd_pkg::pickCode(data);

   // anything not listed leaves every strobe low
   assign wrTogEn   = newFrame && cmd == dac_cmd_pkg::CMD_TOG_EN;
   assign wrMux     = newFrame && cmd == dac_cmd_pkg::CMD_MUX;
   assign wrFault   = newFrame && cmd == dac_cmd_pkg::CMD_FAULT;
   assign wrCodeAll = newFrame && cmd == dac_cmd_pkg::CMD_CODE_ALL;
   assign wrCodeUpd = newFrame && cmd == dac_cmd_pkg::CMD_CODE_UPD_ALL;
   assign wrSetAll  = newFrame && cmd == dac_cmd_pkg::CMD_SET_ALL;
   assign wrSetUpd  = newFrame && cmd == dac_cmd_pkg::CMD_SET_UPD_ALL;
   assign wrUpdAll  = newFrame && cmd == dac_cmd_pkg::CMD_UPD_ALL;
   assign loadAllCode = wrCodeAll | wrCodeUpd;
   assign copyAll     = wrSetUpd | wrUpdAll;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         toggleDitherEnableBits <= dac_cmd_pkg::RST_TOG_EN;
      end else if (wrTogEn) begin
         toggleDitherEnableBits <=
            data[dac_cmd_pkg::TOG_LSB +: NCH];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         monitorMuxOn      <= 1'b0;
         monitorSelectCode <= dac_cmd_pkg::RST_MUX_SEL;
      end else if (wrMux) begin
         monitorMuxOn      <= data[dac_cmd_pkg::MUX_ON_BIT];
         monitorSelectCode <=
            data[dac_cmd_pkg::MUX_SEL_LSB +: dac_cmd_pkg::MUX_SEL_W];
      end
   end

   // a fault event in the write cycle survives the write
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         faultFlags <= dac_cmd_pkg::RST_FAULT;
      end else if (wrFault) begin
         faultFlags <= data[dac_cmd_pkg::FAULT_LSB +: dac_cmd_pkg::FAULT_W]
                       | faultSync_ff;
      end else begin
         faultFlags <= faultFlags | faultSync_ff;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_chan
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               inReg_ff[ch] <= dac_cmd_pkg::RST_CODE;
            end else if (loadAllCode) begin
               inReg_ff[ch] <= newCode;
            end
         end

         // 0x79 bypasses the input register so all outputs move together
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               dacCodeWord[ch] <= dac_cmd_pkg::RST_CODE;
            end else if (wrCodeUpd) begin
               dacCodeWord[ch] <= newCode;
            end else if (copyAll) begin
               dacCodeWord[ch] <= inReg_ff[ch];
            end
         end

         // span in 11:8, toggle source in 13:12 of the settings word
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               chanSetting[ch] <= dac_cmd_pkg::RST_SET;
            end else if (wrSetAll | wrSetUpd) begin
               chanSetting[ch] <=
                  data[dac_cmd_pkg::SET_LSB +: dac_cmd_pkg::SET_W];
            end
         end
      end
   endgenerate

   // readback word keeps the command echo on top and the field in place
   always_comb begin
      nxt_readHold = {cmd, 24'h00_0000};
      readHit      = 1'b1;
      case (cmd[7:4])
         dac_cmd_pkg::NIB_RD_CODE: begin
            if (chanValid) begin
               nxt_readHold[dac_cmd_pkg::CODE16_LSB +: CW] =
                  dacCodeWord[chanAddr[2:0]];
            end
         end
         dac_cmd_pkg::NIB_RD_SET: begin
            if (chanValid) begin
               nxt_readHold[dac_cmd_pkg::SET_LSB +: dac_cmd_pkg::SET_W] =
                  chanSetting[chanAddr[2:0]];
            end
         end
         // no offset or gain trim in this block: those read as zero
         dac_cmd_pkg::NIB_RD_OFS:  readHit = 1'b1;
         dac_cmd_pkg::NIB_RD_GAIN: readHit = 1'b1;
         default: begin
            case (cmd)
               dac_cmd_pkg::CMD_RD_CFG:   readHit = 1'b1;
               dac_cmd_pkg::CMD_RD_PWRDN: readHit = 1'b1;
               dac_cmd_pkg::CMD_RD_ABSEL: readHit = 1'b1;
               dac_cmd_pkg::CMD_RD_SWTOG: readHit = 1'b1;
               dac_cmd_pkg::CMD_RD_TOG_EN:
                  nxt_readHold[dac_cmd_pkg::TOG_LSB +: NCH] =
                     toggleDitherEnableBits;
               dac_cmd_pkg::CMD_RD_MUX: begin
                  nxt_readHold[dac_cmd_pkg::MUX_ON_BIT] = monitorMuxOn;
                  nxt_readHold[dac_cmd_pkg::MUX_SEL_LSB +:
                               dac_cmd_pkg::MUX_SEL_W] = monitorSelectCode;
               end
               dac_cmd_pkg::CMD_RD_FAULT:
                  nxt_readHold[dac_cmd_pkg::FAULT_LSB +:
                               dac_cmd_pkg::FAULT_W] = faultFlags;
               dac_cmd_pkg::CMD_RD_THERMAL:
                  nxt_readHold[dac_cmd_pkg::THERM_LSB +: NCH] = thermSync_ff;
               default: readHit = 1'b0;
            endcase
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         readHold_ff <= 32'h0000_0000;
      end else if (newFrame && readHit) begin
         readHold_ff <= nxt_readHold;
      end
   end

   sequence s_cmd(logic [7:0] c);
      newFrame && cmd == c;
   endsequence

   a_tog_en_load: assert property (
      s_cmd(dac_cmd_pkg::CMD_TOG_EN) |=>
         toggleDitherEnableBits == $past(data[15:8]))
      else $error("toggle enable not loaded from frame");

   a_mux_on_write: assert property (
      s_cmd(dac_cmd_pkg::CMD_MUX) |=> monitorMuxOn == $past(data[18]))
      else $error("monitor mux enable wrong");

   a_mux_sel_write: assert property (
      s_cmd(dac_cmd_pkg::CMD_MUX) |=>
         monitorSelectCode == $past(data[17:8]))
      else $error("monitor select code wrong");

   a_fault_write: assert property (
      s_cmd(dac_cmd_pkg::CMD_FAULT) |=>
         faultFlags == ($past(data[10:8]) | $past(faultSync_ff)))
      else $error("fault register write wrong");

   a_code_all_hold: assert property (
      s_cmd(dac_cmd_pkg::CMD_CODE_ALL) |=>
         inReg_ff[7] == $past(newCode) && $stable(dacCodeWord))
      else $error("code to all touched outputs or missed input");

   a_code_upd_all: assert property (
      s_cmd(dac_cmd_pkg::CMD_CODE_UPD_ALL) |=>
         dacCodeWord[0] == $past(newCode) && dacCodeWord[7] == inReg_ff[7])
      else $error("code and update all failed");

   a_set_upd_all: assert property (
      s_cmd(dac_cmd_pkg::CMD_SET_UPD_ALL) |=>
         chanSetting[3] == $past(data[19:8])
         && dacCodeWord[3] == $past(inReg_ff[3]))
      else $error("settings with update failed");

   a_upd_all: assert property (
      s_cmd(dac_cmd_pkg::CMD_UPD_ALL) |=>
         dacCodeWord == $past(inReg_ff) && $stable(chanSetting))
      else $error("update all did not copy inputs");

   a_read_chan: assert property (
      s_cmd(8'h93) |=> readHold_ff[19:8] == chanSetting[3]
         && readHold_ff[31:24] == 8'h93)
      else $error("channel settings readback wrong");

   a_read_fault: assert property (
      s_cmd(dac_cmd_pkg::CMD_RD_FAULT) |=> readHold_ff[10:8] == faultFlags)
      else $error("fault readback wrong");

   a_nop_quiet: assert property (
      s_cmd(dac_cmd_pkg::CMD_NOP) |=> $stable(readHold_ff)
         && $stable(dacCodeWord) && $stable(toggleDitherEnableBits))
      else $error("no operation changed state");

   a_unknown_quiet: assert property (
      s_cmd(8'h77) |=> $stable(readHold_ff) && $stable(chanSetting)
         && $stable(dacCodeWord) && $stable(monitorSelectCode))
      else $error("unknown command changed state");

   a_span_field: assert property (
      s_cmd(dac_cmd_pkg::CMD_SET_ALL) |=>
         chanSetting[5].spanSetting == $past(data[11:8])
         && chanSetting[5].toggleSourceSelect == $past(data[13:12]))
      else $error("span or toggle source field misplaced");

endmodule

// ===== sim/link_host.sv
// host serial master model: drives framed commands and captures readback
`timescale 1ns/1ns
module link_host (
   output logic      sclkLink,
   output logic      csN,
   output logic      sdi,
   input  wire logic sdo
);
   initial begin
      sclkLink = 1'b0;
      csN = 1'b1;
      sdi = 1'b0;
   end

   // link clock stands still between frames; 12 ns period inside them
   task automatic xfer(input logic [31:0] w, output logic [31:0] rdw);
      rdw = 32'h0;
      csN = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         sdi = w[i];
         #6 sclkLink = 1'b1;
         #6 sclkLink = 1'b0;
         rdw[i] = sdo;
      end
      #6 csN = 1'b1;
      // released line must not keep showing the last bit
      sdi = ~sdi;
   endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench of the serial command decoder
`timescale 1ns/1ns
module tb_top;
   logic                             clk_sys;
   logic                             reset;
   logic                             sclkLink;
   logic                             csN;
   logic                             sdi;
   logic                             sdo;
   logic [2:0]                       faultSetIn;
   logic [7:0]                       thermalStatusIn;
   logic [7:0][15:0]                 dacCodeWord;
   dac_cmd_pkg::chan_set_t [7:0]     chanSetting;
   logic [7:0]                       toggleDitherEnableBits;
   logic                             monitorMuxOn;
   logic [9:0]                       monitorSelectCode;
   dac_cmd_pkg::fault_t              faultFlags;
   logic [31:0]                      rdWord;
   logic [31:0]                      readTab [5];
   int                               n_errors = 0;
   int                               check_count = 0;

   link_host host (
      .sclkLink (sclkLink),
      .csN      (csN),
      .sdi      (sdi),
      .sdo      (sdo)
   );

   dac_serial_command_decoder DUT (
      .clk_sys                (clk_sys),
      .reset                  (reset),
      .sclkLink               (sclkLink),
      .csN                    (csN),
      .sdi                    (sdi),
      .sdo                    (sdo),
      .faultSetIn             (faultSetIn),
      .thermalStatusIn        (thermalStatusIn),
      .dacCodeWord            (dacCodeWord),
      .chanSetting            (chanSetting),
      .toggleDitherEnableBits (toggleDitherEnableBits),
      .monitorMuxOn           (monitorMuxOn),
      .monitorSelectCode      (monitorSelectCode),
      .faultFlags             (faultFlags)
   );

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      if (n_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [127:0] got,
                      input logic [127:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // gap of 6 cycles covers the 3..4 edge latency and readback setup
   task automatic wr(input logic [31:0] w);
      host.xfer(w, rdWord);
      repeat (6) @(negedge clk_sys);
   endtask

   // readback of a read command shows up in the following frame
   task automatic rd(input logic [7:0] cmd, input logic [31:0] exp);
      wr({cmd, 24'h0});
      wr(32'hff000000);
      chk("readback", 128'(rdWord), 128'(exp));
   endtask

   initial begin
      #200000;
      n_errors++;
      complete_run();
   end

   initial begin
      reset = 1'b1;
      faultSetIn = 3'h0;
      thermalStatusIn = 8'h00;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      @(negedge clk_sys);
      chk("tog", 128'(toggleDitherEnableBits), 128'h0);
      chk("muxon", 128'(monitorMuxOn), 128'h0);
      chk("sel", 128'(monitorSelectCode), 128'h0);
      chk("fault", 128'(faultFlags), 128'h0);
      chk("set", 128'(chanSetting), 128'h0);
      chk("dac", 128'(dacCodeWord), 128'h0);
      wr(32'h7400a500);
      chk("tog", 128'(toggleDitherEnableBits), 128'ha5);
      rd(8'hf4, 32'hf400a500);
      wr(32'h7507ff00);
      chk("muxon", 128'(monitorMuxOn), 128'h1);
      chk("sel", 128'(monitorSelectCode), 128'h3ff);
      rd(8'hf5, 32'hf507ff00);
      wr(32'h75000100);
      chk("muxon", 128'(monitorMuxOn), 128'h0);
      chk("sel", 128'(monitorSelectCode), 128'h1);
      wr(32'h76000500);
      chk("fault", 128'(faultFlags), 128'h5);
      rd(8'hf6, 32'hf6000500);
      wr(32'h76000000);
      chk("fault", 128'(faultFlags), 128'h0);
      faultSetIn = 3'h2;
      repeat (2) @(negedge clk_sys);
      faultSetIn = 3'h0;
      repeat (6) @(negedge clk_sys);
      chk("fault", 128'(faultFlags), 128'h2);
      wr(32'h76000000);
      chk("fault", 128'(faultFlags), 128'h0);
      wr(32'h78beef00);
      chk("dac", 128'(dacCodeWord), 128'h0);
      wr(32'h7c000000);
      chk("dac", 128'(dacCodeWord), {8{16'hbeef}});
      wr(32'h79123400);
      chk("dac", 128'(dacCodeWord), {8{16'h1234}});
      wr(32'h7a0abc00);
      chk("set", 128'(chanSetting), 128'({8{12'habc}}));
      chk("span", 128'(chanSetting[4].spanSetting), 128'hc);
      chk("tsel", 128'(chanSetting[6].toggleSourceSelect), 128'h3);
      chk("dac", 128'(dacCodeWord), {8{16'h1234}});
      wr(32'h78555500);
      wr(32'h7b012300);
      chk("set", 128'(chanSetting), 128'({8{12'h123}}));
      chk("dac", 128'(dacCodeWord), {8{16'h5555}});
      // per-channel reads; the last one names a channel that does not exist
      readTab = '{32'h85555500, 32'h93012300, 32'ha2000000, 32'hb7000000,
                  32'h8c000000};
      foreach (readTab[i])
         rd(readTab[i][31:24], readTab[i]);
      for (int c = 0; c < 4; c++)
         rd(8'hf0 + 8'(c), {8'hf0 + 8'(c), 24'h0});
      thermalStatusIn = 8'h3c;
      repeat (4) @(negedge clk_sys);
      rd(8'hf7, 32'hf7003c00);
      // unknown code and no-operation leave state and readback alone
      wr(32'hf4000000);
      wr(32'h77ffffff);
      chk("readback", 128'(rdWord), 128'hf400a500);
      wr(32'hff000000);
      chk("readback", 128'(rdWord), 128'hf400a500);
      wr(32'hff000000);
      chk("readback", 128'(rdWord), 128'hf400a500);
      chk("tog", 128'(toggleDitherEnableBits), 128'ha5);
      chk("set", 128'(chanSetting), 128'({8{12'h123}}));
      chk("dac", 128'(dacCodeWord), {8{16'h5555}});
      chk("fault", 128'(faultFlags), 128'h0);
      chk("sel", 128'(monitorSelectCode), 128'h1);
      complete_run();
   end
endmodule
